/* rtl/pfc_port_failover.sv */
/*
 * Per-port failover configuration register with failover load logic.
 * Assumes a classic Wishbone master on the core clock and failover
 * strobes from logic on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pfc_regs.svh"

module pfc_port_failover
    import pfc_pkg::*;
(
    input wire logic i_core_clk, // 20 MHz core clock
    input wire logic i_rst_b, // Sync reset, active low
    input wire logic i_wb_cyc, // Wishbone cycle
    input wire logic i_wb_stb, // Wishbone strobe
    input wire logic i_wb_we, // Write enable
    input wire logic [7:0] i_wb_adr, // Byte address
    input wire logic [3:0] i_wb_sel, // Byte lanes
    input wire logic [31:0] i_wb_dat, // Write data
    output logic [31:0] o_wb_dat, // Read data
    output logic o_wb_ack, // Acknowledge
    input wire logic i_primary_event, // Primary failover strobe
    input wire logic i_secondary_event, // Secondary failover strobe
    output pfc_port_cfg_t o_live_cfg, // Live port control fields
    output logic o_live_load, // Live fields updated pulse
    output logic o_primary_switch_flag, // Sticky primary status
    output logic o_secondary_switch_flag, // Sticky secondary status
    output pfc_state_t o_current_switch_state // Current failover state
);

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic ack_q, ack_d;
    logic req;
    logic wr;
    logic [31:0] wmask;

    assign req = i_wb_cyc && i_wb_stb && !ack_q;
    assign wr = req && i_wb_we;
    assign wmask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [31:0] fctl_q, fctl_d;
    pfc_state_t state_q, state_d;
    logic pflag_q, pflag_d;
    logic sflag_q, sflag_d;
    pfc_port_cfg_t live_q, live_d;
    logic load_q, load_d;
    logic [31:0] rdata_q, rdata_d;
    logic soft_trig;
    logic do_pri;
    logic do_sec;

    // ------------------------------------------------------------------
    // Failover direction
    // ------------------------------------------------------------------
    logic clr_wr;

    // Soft trigger is a write-one strobe; the bit itself never stores
    assign soft_trig = wr && (i_wb_adr == `PFC_OFF_SWITCH_CONTROL) && i_wb_sel[0]
                       && i_wb_dat[`PFC_TRIG_BIT];
    // Status clears ride on byte lane 0 only
    assign clr_wr = wr && (i_wb_adr == `PFC_OFF_SWITCH_STATUS) && i_wb_sel[0];

    // Direction uses the state before the edge, so one trigger moves once
    always_comb begin
        do_pri = i_primary_event || (soft_trig && state_q == PFC_ST_SECONDARY);
        do_sec = !do_pri && (i_secondary_event || (soft_trig && state_q == PFC_ST_PRIMARY));
    end

    // ------------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------------
    // Registered ack: one cycle after the taking edge, gone the next
    always_comb begin
        ack_d = req;
        rdata_d = 32'h00000000;
        if (req && !i_wb_we) begin
            unique case (i_wb_adr)
                `PFC_OFF_FAILOVER_CONTROL: rdata_d = fctl_q;
                `PFC_OFF_SWITCH_STATUS: rdata_d = {29'h00000000, sflag_q, pflag_q, state_q};
                default: rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Failover settings register
    // ------------------------------------------------------------------
    always_comb begin
        fctl_d = fctl_q;
        if (wr && i_wb_adr == `PFC_OFF_FAILOVER_CONTROL) begin
            // Reserved bits never store, so they read zero
            fctl_d = (fctl_q & ~(wmask & `PFC_FCTL_WMASK)) | (i_wb_dat & wmask & `PFC_FCTL_WMASK);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            fctl_q <= `PFC_FCTL_RESET;
        end else begin
            fctl_q <= fctl_d;
        end
    end

    // ------------------------------------------------------------------
    // Live port fields and failover state
    // ------------------------------------------------------------------
    // Kind codes pass through unchecked; software keeps to the legal set
    always_comb begin
        live_d = live_q;
        state_d = state_q;
        load_d = 1'b0;
        // Primary wins a same-cycle collision
        if (do_pri) begin
            live_d.port_kind = fctl_q[`PFC_PKIND_LSB +: 4];
            live_d.partition_sel = fctl_q[`PFC_PPART_LSB +: 3];
            live_d.device_index = fctl_q[`PFC_PDEV_LSB +: 5];
            state_d = PFC_ST_PRIMARY;
            load_d = 1'b1;
        end else if (do_sec) begin
            live_d.port_kind = fctl_q[`PFC_SKIND_LSB +: 4];
            live_d.partition_sel = fctl_q[`PFC_SPART_LSB +: 3];
            live_d.device_index = fctl_q[`PFC_SDEV_LSB +: 5];
            state_d = PFC_ST_SECONDARY;
            load_d = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            state_q <= PFC_ST_PRIMARY;
            live_q <= '0;
            load_q <= 1'b0;
        end else begin
            state_q <= state_d;
            live_q <= live_d;
            load_q <= load_d;
        end
    end

    // ------------------------------------------------------------------
    // Sticky status flags
    // ------------------------------------------------------------------
    always_comb begin
        pflag_d = pflag_q;
        sflag_d = sflag_q;
        if (clr_wr && i_wb_dat[`PFC_PFLAG_BIT]) begin
            pflag_d = 1'b0;
        end
        if (clr_wr && i_wb_dat[`PFC_SFLAG_BIT]) begin
            sflag_d = 1'b0;
        end
        // Set wins over a clear landing in the same cycle, so no event is lost
        if (do_pri) begin
            pflag_d = 1'b1;
        end
        if (do_sec) begin
            sflag_d = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            pflag_q <= 1'b0;
            sflag_q <= 1'b0;
        end else begin
            pflag_q <= pflag_d;
            sflag_q <= sflag_d;
        end
    end

    assign o_wb_ack = ack_q;
    assign o_wb_dat = rdata_q;
    assign o_live_cfg = live_q;
    assign o_live_load = load_q;
    assign o_primary_switch_flag = pflag_q;
    assign o_secondary_switch_flag = sflag_q;
    assign o_current_switch_state = state_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);

    AST_PRI_KIND: assert property (i_primary_event |=> o_live_cfg.port_kind == $past(fctl_q[3:0]))
        else $error("primary kind not loaded");
    AST_PRI_PART: assert property (i_primary_event |=> o_live_cfg.partition_sel == $past(fctl_q[6:4]))
        else $error("primary partition not loaded");
    AST_PRI_DEV: assert property (i_primary_event |=> o_live_cfg.device_index == $past(fctl_q[14:10]))
        else $error("primary device not loaded");
    AST_SEC_KIND: assert property (i_secondary_event && !i_primary_event && !soft_trig
        |=> o_live_cfg.port_kind == $past(fctl_q[19:16]))
        else $error("secondary kind not loaded");
    AST_SEC_PART: assert property (i_secondary_event && !i_primary_event && !soft_trig
        |=> o_live_cfg.partition_sel == $past(fctl_q[22:20]))
        else $error("secondary partition not loaded");
    AST_SEC_DEV: assert property (i_secondary_event && !i_primary_event && !soft_trig
        |=> o_live_cfg.device_index == $past(fctl_q[30:26]))
        else $error("secondary device not loaded");
    AST_SOFT_DIR: assert property (soft_trig && !i_primary_event && !i_secondary_event
        |=> o_current_switch_state != $past(o_current_switch_state))
        else $error("soft trigger did not flip state");
    AST_PFLAG_STICKY: assert property (i_primary_event ##1 !(wr && i_wb_adr == 8'h08) [*2]
        |-> o_primary_switch_flag)
        else $error("primary flag lost");
    AST_RSVD_ZERO: assert property (1'b1 |-> (fctl_q & ~32'h7C7F7C7F) == 32'h00000000)
        else $error("reserved bits set");
    AST_KIND_SET: assert property (o_live_load |-> o_live_cfg.port_kind == $past(fctl_q[3:0])
        || o_live_cfg.port_kind == $past(fctl_q[19:16]))
        else $error("live kind from no source");

    // Bus handshake
    AST_ACK_PULSE: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack held longer than one cycle");
    AST_ACK_ANSWER: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("request not answered");
    AST_ACK_CAUSE: assert property (o_wb_ack |-> $past(i_wb_cyc) && $past(i_wb_stb))
        else $error("ack without request");
    AST_RDATA_IDLE: assert property (!o_wb_ack |-> o_wb_dat == 32'h00000000)
        else $error("read data outside ack");
    AST_FCTL_WRITE: assert property (wr && i_wb_adr == 8'h00 && (&i_wb_sel)
        |=> fctl_q == ($past(i_wb_dat) & 32'h7C7F7C7F))
        else $error("full write not stored");

    // Event loads and state
    AST_PRI_STATE: assert property (i_primary_event |=> o_current_switch_state == PFC_ST_PRIMARY)
        else $error("primary event left wrong state");
    AST_SEC_STATE: assert property (i_secondary_event && !i_primary_event && !soft_trig
        |=> o_current_switch_state == PFC_ST_SECONDARY)
        else $error("secondary event left wrong state");
    AST_LOAD_PULSE: assert property (i_primary_event || i_secondary_event |=> o_live_load)
        else $error("load pulse missing");
    AST_LIVE_HOLD: assert property (!i_primary_event && !i_secondary_event && !soft_trig
        |=> !o_live_load && $stable(o_live_cfg))
        else $error("live fields moved without event");
    AST_SOFT_TO_SEC: assert property (soft_trig && !i_primary_event && !i_secondary_event
        && o_current_switch_state == PFC_ST_PRIMARY
        |=> o_current_switch_state == PFC_ST_SECONDARY && o_secondary_switch_flag)
        else $error("soft trigger from primary did not go secondary");
    AST_SOFT_TO_PRI: assert property (soft_trig && !i_primary_event && !i_secondary_event
        && o_current_switch_state == PFC_ST_SECONDARY
        |=> o_current_switch_state == PFC_ST_PRIMARY && o_primary_switch_flag)
        else $error("soft trigger from secondary did not go primary");

    // Status flags
    AST_PFLAG_SET: assert property (i_primary_event |=> o_primary_switch_flag)
        else $error("primary flag not set");
    AST_SFLAG_SET: assert property (i_secondary_event && !i_primary_event && !soft_trig
        |=> o_secondary_switch_flag)
        else $error("secondary flag not set");
    AST_PCLR: assert property (clr_wr && i_wb_dat[1] && !do_pri |=> !o_primary_switch_flag)
        else $error("primary flag not cleared");
    AST_SCLR: assert property (clr_wr && i_wb_dat[2] && !do_sec |=> !o_secondary_switch_flag)
        else $error("secondary flag not cleared");
    AST_FLAG_HOLD: assert property (!do_pri && !wr |=> $stable(o_primary_switch_flag))
        else $error("primary flag moved on its own");

    COV_PRI: cover property (i_primary_event ##1 o_live_load);
    COV_SEC: cover property (i_secondary_event && !i_primary_event ##1 o_live_load);
    COV_SOFT: cover property (soft_trig ##[1:20] soft_trig);
    COV_CLEAR: cover property (o_primary_switch_flag ##1 !o_primary_switch_flag);
    COV_COLLIDE: cover property (i_primary_event && i_secondary_event);

endmodule
`default_nettype wire

/* rtl/pfc_regs.svh */
/*
 * Register map, field positions and reset values of the port failover
 * configuration block. Assumes a 32-bit classic Wishbone register bus.
 */
`ifndef PFC_REGS_SVH
`define PFC_REGS_SVH

// ----------------------------------------------------------------------
// Offsets (byte addresses)
// ----------------------------------------------------------------------
`define PFC_OFF_FAILOVER_CONTROL 8'h00
`define PFC_OFF_SWITCH_CONTROL 8'h04
`define PFC_OFF_SWITCH_STATUS 8'h08

// ----------------------------------------------------------------------
// Field positions of port_failover_control
// ----------------------------------------------------------------------
`define PFC_PKIND_LSB 0
`define PFC_PPART_LSB 4
`define PFC_PDEV_LSB 10
`define PFC_SKIND_LSB 16
`define PFC_SPART_LSB 20
`define PFC_SDEV_LSB 26
`define PFC_FCTL_WMASK 32'h7C7F7C7F

// ----------------------------------------------------------------------
// Switch control and status bits
// ----------------------------------------------------------------------
`define PFC_TRIG_BIT 0
`define PFC_STATE_BIT 0
`define PFC_PFLAG_BIT 1
`define PFC_SFLAG_BIT 2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PFC_FCTL_RESET 32'h00000000

`endif

/* rtl/pfc_pkg.sv */
/*
 * Types of the port failover configuration block.
 * Assumes nothing beyond the register header.
 */
package pfc_pkg;
    typedef enum logic [3:0] {
        PFC_KIND_DISABLED = 4'h0,
        PFC_KIND_DOWNSTREAM = 4'h1,
        PFC_KIND_UPSTREAM = 4'h2,
        PFC_KIND_NT = 4'h3,
        PFC_KIND_UP_NT = 4'h4,
        PFC_KIND_UNATTACHED = 4'h5,
        PFC_KIND_UP_DMA = 4'h6,
        PFC_KIND_UP_NT_DMA = 4'h7,
        PFC_KIND_NT_DMA = 4'h8
    } pfc_kind_t;

    typedef enum logic {
        PFC_ST_PRIMARY = 1'b0,
        PFC_ST_SECONDARY = 1'b1
    } pfc_state_t;

    typedef struct packed {
        logic [3:0] port_kind;
        logic [2:0] partition_sel;
        logic [4:0] device_index;
    } pfc_port_cfg_t;
endpackage

/* testbench/pfc_port_failover_test.sv */
/*
 * Bench for pfc_port_failover: Wishbone register tasks and failover strobes.
 * Assumes the design acks each request within a few cycles.
 */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
    $display("FAIL %s exp %h got %h", n, e, g); end end

module pfc_port_failover_test;
    import pfc_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hF;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic pev = 1'b0;
    logic sev = 1'b0;
    pfc_port_cfg_t live;
    logic load;
    logic pflag;
    logic sflag;
    pfc_state_t state;
    int err_total = 0;
    int comparisons = 0;

    pfc_port_failover pfc_port_failover_i (
        .i_core_clk(clk), .i_rst_b(rst_b), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
        .i_primary_event(pev), .i_secondary_event(sev), .o_live_cfg(live), .o_live_load(load),
        .o_primary_switch_flag(pflag), .o_secondary_switch_flag(sflag),
        .o_current_switch_state(state)
    );

    initial begin
        forever #25 clk = ~clk;
    end

    task automatic stop_test();
        if (err_total == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------------
    // Bus and strobe tasks
    // ----------------------------------------------------------------------
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            err_total++;
            stop_test();
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    // One-cycle strobe, then let the loaded fields settle
    task automatic fire(input logic sec);
        @(posedge clk);
        pev <= !sec;
        sev <= sec;
        @(posedge clk);
        pev <= 1'b0;
        sev <= 1'b0;
        @(posedge clk);
        `CHK("load", 1'b1, load)
        @(posedge clk);
    endtask

    // ----------------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------------
    initial begin
        logic [31:0] rd;
        logic [31:0] w;
        logic [3:0] pk, sk;
        logic [2:0] pp, sp;
        logic [4:0] pd, sd;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        wb(1'b0, 8'h00, 32'h0, rd); `CHK("fctl_rst", 32'h0, rd)
        wb(1'b0, 8'h08, 32'h0, rd); `CHK("stat_rst", 32'h0, rd)
        wb(1'b1, 8'h00, 32'hFFFFFFFF, rd);
        wb(1'b0, 8'h00, 32'h0, rd); `CHK("fctl_rsv", 32'h7C7F7C7F, rd)
        // Every kind code in both fields, mirrored so each field sees all values
        for (int k = 0; k <= 8; k++) begin
            pk = 4'(k);
            sk = 4'(8 - k);
            pp = 3'(k);
            sp = ~3'(k);
            pd = 5'(k * 3);
            sd = 5'(31 - k);
            w = {1'b0, sd, 3'h0, sp, sk, 1'b0, pd, 3'h0, pp, pk};
            wb(1'b1, 8'h00, w, rd);
            wb(1'b0, 8'h00, 32'h0, rd); `CHK("fctl", w, rd)
            fire(1'b0); `CHK("live_p", {pk, pp, pd}, live)
            fire(1'b1); `CHK("live_s", {sk, sp, sd}, live)
            `CHK("flags", 2'b11, {pflag, sflag})
        end
        // Soft trigger flips direction; last setup has pk 8, sk 0
        wb(1'b1, 8'h04, 32'h1, rd);
        repeat (2) @(posedge clk);
        `CHK("trig_p", {4'h8, 3'h0, 5'h18}, live)
        `CHK("state_p", PFC_ST_PRIMARY, state)
        wb(1'b1, 8'h04, 32'h1, rd);
        repeat (2) @(posedge clk);
        `CHK("trig_s", {4'h0, 3'h7, 5'h17}, live)
        wb(1'b0, 8'h04, 32'h0, rd); `CHK("trig_rd", 32'h0, rd)
        // Clear only the primary flag first, then the other
        wb(1'b1, 8'h08, 32'h2, rd);
        wb(1'b0, 8'h08, 32'h0, rd); `CHK("w1c_p", 32'h5, rd)
        wb(1'b1, 8'h08, 32'h4, rd);
        wb(1'b0, 8'h08, 32'h0, rd); `CHK("w1c_s", 32'h1, rd)
        // Both strobes together: primary must win
        @(posedge clk);
        pev <= 1'b1;
        sev <= 1'b1;
        @(posedge clk);
        pev <= 1'b0;
        sev <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK("both_live", {4'h8, 3'h0, 5'h18}, live)
        `CHK("both_state", PFC_ST_PRIMARY, state)
        `CHK("both_sflag", 1'b0, sflag)
        `CHK("both_pflag", 1'b1, pflag)
        // Unmapped place must not disturb the real register
        wb(1'b1, 8'hFC, 32'hFFFFFFFF, rd);
        wb(1'b0, 8'hFC, 32'h0, rd); `CHK("unmapped", 32'h0, rd)
        wb(1'b0, 8'h00, 32'h0, rd); `CHK("fctl_keep", w, rd)
        // Lane 0 only: the upper bytes must keep their values
        sel <= 4'h1;
        wb(1'b1, 8'h00, 32'h0, rd);
        sel <= 4'hF;
        wb(1'b0, 8'h00, 32'h0, rd); `CHK("sel_lane", w & 32'hFFFFFF00, rd)
        // Second reset mid-run
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        wb(1'b0, 8'h00, 32'h0, rd); `CHK("fctl_rst2", 32'h0, rd)
        `CHK("live_rst2", 12'h000, live)
        stop_test();
    end

    // Hang guard
    initial begin
        repeat (100000) @(posedge clk);
        err_total++;
        stop_test();
    end
endmodule
`default_nettype wire
